// ### hw/smpc_pkg.sv
package smpc_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] TX_FSK_CTRL1_IDX = 16'h01F1;
  localparam logic [15:0] RX_CTRL0_IDX = 16'h01F2;
  localparam logic [15:0] TX_PREAMBLE_IDX = 16'h0474;
  localparam logic [17:0] TX_FSK_CTRL1_ADDR = {TX_FSK_CTRL1_IDX, 2'b00};
  localparam logic [17:0] RX_CTRL0_ADDR = {RX_CTRL0_IDX, 2'b00};
  localparam logic [17:0] TX_PREAMBLE_ADDR = {TX_PREAMBLE_IDX, 2'b00};

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] TX_FSK_CTRL1_RST = 8'h0C;
  localparam logic [2:0] RX_CTRL0_RST = 3'h0;
  localparam logic [9:0] TX_PREAMBLE_RST = 10'h010;

  // ****************************************************************
  // field positions of the transmit control byte
  // ****************************************************************
  localparam int TX_FEC_ON_POS = 0;
  localparam int TX_FEC_ENC_POS = 1;
  localparam int TX_CRC_LEN_POS = 2;
  localparam int TX_WHITEN_POS = 3;
  localparam int TX_PHR_ONE_POS = 4;
  localparam int TX_PHR_TWO_POS = 5;
  localparam int TX_INTLV_POS = 6;
  localparam int TX_SFD_POS = 7;

  // field positions of the receive control byte
  localparam int RX_SET_A_POS = 0;
  localparam int RX_SET_B_POS = 1;
  localparam int RX_EN_POS = 2;

  // width of the preamble byte count
  localparam int PREAMBLE_W = 10;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] tx_ctrl;
    logic [2:0] rx_ctrl;
    logic [PREAMBLE_W-1:0] preamble;
    logic msf_pending;
    logic switched_active;
    logic rx_go;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smpc_state_t;

  typedef struct packed {
    logic fec_on;
    logic fec_encoder_sel;
    logic crc_len_sel;
    logic whiten_on;
    logic phr_bit_one;
    logic phr_bit_two;
    logic interleave_on;
    logic sfd_variant_sel;
    logic [PREAMBLE_W-1:0] preamble_bytes;
  } smpc_tx_cfg_t;

endpackage : smpc_pkg

// ### hw/smpc_top.sv
`timescale 1ns/1ps
// What this block does
// RQ1: forward error correction on switched transmit only while fec enable bit is one
// RQ2: encoder select zero picks nrnsc encoder, one picks rsc encoder
// RQ3: crc length select zero gives 32-bit crc, one gives 16-bit crc
// RQ4: whitening enable one whitens switched transmit data, zero leaves it plain
// RQ5: the two phr register bits go to phr bit positions 1 and 2
// RQ6: interleave when enable is one; software sets it with nrnsc encoder
// RQ7: sfd variant sent equals the sfd select bit
// RQ8: transmit control register resets to 0Ch
// RQ9: software keeps preamble byte count between 0004h and 03E8h
// RQ10: preamble length field resets to 0010h
// RQ11: software writes zeros to preamble register bits 15 to 10
// RQ12: mode switch frame with setting bit one applies settings at next trigger
// RQ13: software keeps second setting bit equal to the first
// RQ14: receive enable zero blocks switched reception even at modem timing
// RQ15: software writes zeros to receive control bits 7 to 3
// RQ16: receive control register resets to 00h
module smpc_top #(
  parameter int ADDR_W = 18
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_msf_rx,
  input wire logic i_rx_trigger,
  input wire logic i_modem_rx_timing,
  output smpc_pkg::smpc_tx_cfg_t o_tx_cfg,
  output logic o_switched_active,
  output logic o_rx_switched_go
);

  // ****************************************************************
  // state
  // ****************************************************************
  smpc_pkg::smpc_state_t state_q;
  smpc_pkg::smpc_state_t state_d;

  logic setup_phase;
  logic wr_fire;
  logic hit_tx;
  logic hit_rx;
  logic hit_pre;

  // address decode and phase
  assign setup_phase = i_psel & ~i_penable;
  assign wr_fire = i_psel & i_penable & state_q.pready & i_pwrite & ~state_q.pslverr;
  assign hit_tx = i_paddr == ADDR_W'(smpc_pkg::TX_FSK_CTRL1_ADDR);
  assign hit_rx = i_paddr == ADDR_W'(smpc_pkg::RX_CTRL0_ADDR);
  assign hit_pre = i_paddr == ADDR_W'(smpc_pkg::TX_PREAMBLE_ADDR);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    // bus answer: one wait-free access cycle after setup
    state_d.pready = setup_phase;
    state_d.pslverr = setup_phase & ~(hit_tx | hit_rx | hit_pre);
    state_d.prdata = 32'h0000_0000;
    if (setup_phase && !i_pwrite) begin
      if (hit_tx) begin
        state_d.prdata = {24'h00_0000, state_q.tx_ctrl};
      end else if (hit_rx) begin
        state_d.prdata = {29'h0000_0000, state_q.rx_ctrl}; // RQ15
      end else if (hit_pre) begin
        state_d.prdata = {22'h00_0000, state_q.preamble}; // RQ11
      end
    end
    // register writes, only on byte lanes enabled
    if (wr_fire && hit_tx && i_pstrb[0]) begin
      state_d.tx_ctrl = i_pwdata[7:0];
    end
    if (wr_fire && hit_rx && i_pstrb[0]) begin
      state_d.rx_ctrl = i_pwdata[2:0]; // RQ15
    end
    if (wr_fire && hit_pre) begin
      if (i_pstrb[0]) begin
        state_d.preamble[7:0] = i_pwdata[7:0];
      end
      if (i_pstrb[1]) begin
        state_d.preamble[9:8] = i_pwdata[9:8]; // RQ11
      end
    end
    // mode switch frame arms the switch while setting bit is set
    if (!state_q.rx_ctrl[smpc_pkg::RX_SET_A_POS]) begin
      state_d.msf_pending = 1'b0;
      state_d.switched_active = 1'b0;
    end else begin
      if (i_rx_trigger && state_q.msf_pending) begin
        state_d.switched_active = 1'b1; // RQ12
        state_d.msf_pending = 1'b0;
      end
      if (i_msf_rx) begin
        state_d.msf_pending = 1'b1; // RQ12
      end
    end
    // reception only with enable bit and modem timing
    state_d.rx_go = i_modem_rx_timing & state_q.switched_active
      & state_q.rx_ctrl[smpc_pkg::RX_EN_POS]; // RQ14
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= '0;
      state_q.tx_ctrl <= smpc_pkg::TX_FSK_CTRL1_RST; // RQ8
      state_q.rx_ctrl <= smpc_pkg::RX_CTRL0_RST; // RQ16
      state_q.preamble <= smpc_pkg::TX_PREAMBLE_RST; // RQ10
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_prdata = state_q.prdata;
  assign o_pready = state_q.pready;
  assign o_pslverr = state_q.pslverr;
  assign o_switched_active = state_q.switched_active;
  assign o_rx_switched_go = state_q.rx_go;
  // transmit configuration fields to the modem
  assign o_tx_cfg.fec_on = state_q.tx_ctrl[smpc_pkg::TX_FEC_ON_POS]; // RQ1
  assign o_tx_cfg.fec_encoder_sel = state_q.tx_ctrl[smpc_pkg::TX_FEC_ENC_POS]; // RQ2
  assign o_tx_cfg.crc_len_sel = state_q.tx_ctrl[smpc_pkg::TX_CRC_LEN_POS]; // RQ3
  assign o_tx_cfg.whiten_on = state_q.tx_ctrl[smpc_pkg::TX_WHITEN_POS]; // RQ4
  assign o_tx_cfg.phr_bit_one = state_q.tx_ctrl[smpc_pkg::TX_PHR_ONE_POS]; // RQ5
  assign o_tx_cfg.phr_bit_two = state_q.tx_ctrl[smpc_pkg::TX_PHR_TWO_POS]; // RQ5
  assign o_tx_cfg.interleave_on = state_q.tx_ctrl[smpc_pkg::TX_INTLV_POS]; // RQ6
  assign o_tx_cfg.sfd_variant_sel = state_q.tx_ctrl[smpc_pkg::TX_SFD_POS]; // RQ7
  assign o_tx_cfg.preamble_bytes = state_q.preamble; // RQ9

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  reset_tx_value_a: assert property ($rose(!i_reset) |-> o_tx_cfg.crc_len_sel // RQ8
    && o_tx_cfg.whiten_on && !o_tx_cfg.fec_on && !o_tx_cfg.sfd_variant_sel)
    else $error("transmit control not at reset value");

  reset_pre_len_a: assert property ($rose(!i_reset) |-> o_tx_cfg.preamble_bytes == 10'h010) // RQ10
    else $error("preamble length not at reset value");

  reset_rx_ctrl_a: assert property ($rose(!i_reset) |-> !o_switched_active && !o_rx_switched_go) // RQ16
    else $error("receive control not cleared at reset");

  tx_fec_write_a: assert property (wr_fire && hit_tx && i_pstrb[0] // RQ1
    |=> o_tx_cfg.fec_on == $past(i_pwdata[0]) && o_tx_cfg.fec_encoder_sel == $past(i_pwdata[1]))
    else $error("fec bits did not follow write");

  tx_sfd_write_a: assert property (wr_fire && hit_tx && i_pstrb[0] // RQ7
    |=> o_tx_cfg.sfd_variant_sel == $past(i_pwdata[7])
    && o_tx_cfg.phr_bit_two == $past(i_pwdata[5]))
    else $error("sfd or phr bit did not follow write");

  switch_apply_a: assert property (state_q.msf_pending && i_rx_trigger // RQ12
    && state_q.rx_ctrl[0] |=> o_switched_active)
    else $error("switch not applied at trigger");

  switch_hold_a: assert property (!o_switched_active && !state_q.msf_pending // RQ12
    |=> !o_switched_active)
    else $error("switch applied without frame");

  rx_block_a: assert property (!state_q.rx_ctrl[2] |=> !o_rx_switched_go) // RQ14
    else $error("switched reception while disabled");

  apb_answer_a: assert property (setup_phase |=> o_pready ##1 !o_pready || i_psel)
    else $error("bus answer not in access cycle");

  // ****************************************************************
  // checks of the transmit control fields
  // ****************************************************************
  // every field follows its own write bit one cycle later
  tx_crc_write_a: assert property (wr_fire && hit_tx && i_pstrb[0] // RQ3
    |=> o_tx_cfg.crc_len_sel == $past(i_pwdata[2]))
    else $error("crc length select did not follow write");

  tx_whiten_write_a: assert property (wr_fire && hit_tx && i_pstrb[0] // RQ4
    |=> o_tx_cfg.whiten_on == $past(i_pwdata[3]))
    else $error("whitening enable did not follow write");

  tx_phr_write_a: assert property (wr_fire && hit_tx && i_pstrb[0] // RQ5
    |=> o_tx_cfg.phr_bit_one == $past(i_pwdata[4]))
    else $error("first phr bit did not follow write");

  tx_intlv_write_a: assert property (wr_fire && hit_tx && i_pstrb[0] // RQ6
    |=> o_tx_cfg.interleave_on == $past(i_pwdata[6]))
    else $error("interleave enable did not follow write");

  // fields stand still while no write reaches them
  tx_fec_hold_a: assert property (!(wr_fire && hit_tx && i_pstrb[0]) // RQ1
    |=> $stable(o_tx_cfg.fec_on))
    else $error("fec enable changed without write");

  tx_enc_hold_a: assert property (!(wr_fire && hit_tx && i_pstrb[0]) // RQ2
    |=> $stable(o_tx_cfg.fec_encoder_sel))
    else $error("encoder select changed without write");

  tx_crc_hold_a: assert property (!(wr_fire && hit_tx && i_pstrb[0]) // RQ3
    |=> $stable(o_tx_cfg.crc_len_sel))
    else $error("crc length select changed without write");

  tx_whiten_hold_a: assert property (!(wr_fire && hit_tx && i_pstrb[0]) // RQ4
    |=> $stable(o_tx_cfg.whiten_on))
    else $error("whitening enable changed without write");

  tx_phr_hold_a: assert property (!(wr_fire && hit_tx && i_pstrb[0]) // RQ5
    |=> $stable(o_tx_cfg.phr_bit_one) && $stable(o_tx_cfg.phr_bit_two))
    else $error("phr bits changed without write");

  tx_intlv_hold_a: assert property (!(wr_fire && hit_tx && i_pstrb[0]) // RQ6
    |=> $stable(o_tx_cfg.interleave_on))
    else $error("interleave enable changed without write");

  tx_sfd_hold_a: assert property (!(wr_fire && hit_tx && i_pstrb[0]) // RQ7
    |=> $stable(o_tx_cfg.sfd_variant_sel))
    else $error("sfd select changed without write");

  reset_tx_reg_a: assert property ($rose(!i_reset) |-> state_q.tx_ctrl == 8'h0C) // RQ8
    else $error("transmit control byte not at reset value");

  // ****************************************************************
  // checks of the preamble length
  // ****************************************************************
  // low and high lanes land on their own bits only
  pre_low_write_a: assert property (wr_fire && hit_pre && i_pstrb[0] // RQ9
    |=> o_tx_cfg.preamble_bytes[7:0] == $past(i_pwdata[7:0]))
    else $error("preamble low byte did not follow write");

  pre_high_write_a: assert property (wr_fire && hit_pre && i_pstrb[1] // RQ11
    |=> o_tx_cfg.preamble_bytes[9:8] == $past(i_pwdata[9:8]))
    else $error("preamble high bits did not follow write");

  pre_low_keep_a: assert property (wr_fire && hit_pre && !i_pstrb[0] // RQ9
    |=> $stable(o_tx_cfg.preamble_bytes[7:0]))
    else $error("preamble low byte changed with lane off");

  pre_hold_a: assert property (!(wr_fire && hit_pre) // RQ9
    |=> $stable(o_tx_cfg.preamble_bytes))
    else $error("preamble length changed without write");

  // ****************************************************************
  // checks of the receive control and switch
  // ****************************************************************
  // control bits, pending frame and switch state
  rx_ctrl_write_a: assert property (wr_fire && hit_rx && i_pstrb[0] // RQ15
    |=> state_q.rx_ctrl == $past(i_pwdata[2:0]))
    else $error("receive control did not follow write");

  rx_ctrl_hold_a: assert property (!(wr_fire && hit_rx && i_pstrb[0]) // RQ16
    |=> $stable(state_q.rx_ctrl))
    else $error("receive control changed without write");

  reset_rx_reg_a: assert property ($rose(!i_reset) |-> state_q.rx_ctrl == 3'h0) // RQ16
    else $error("receive control byte not at reset value");

  msf_arm_a: assert property (i_msf_rx && state_q.rx_ctrl[0] // RQ12
    |=> state_q.msf_pending)
    else $error("mode switch frame not remembered");

  msf_none_a: assert property (!state_q.msf_pending && !i_msf_rx // RQ12
    |=> !state_q.msf_pending)
    else $error("pending frame without mode switch frame");

  msf_clear_a: assert property (!state_q.rx_ctrl[0] // RQ12
    |=> !state_q.msf_pending)
    else $error("pending frame kept with setting bit off");

  switch_clear_a: assert property (!state_q.rx_ctrl[0] // RQ12
    |=> !o_switched_active)
    else $error("switch kept with setting bit off");

  switch_keep_a: assert property (o_switched_active && state_q.rx_ctrl[0] // RQ12
    |=> o_switched_active)
    else $error("switch dropped with setting bit on");

  rx_go_on_a: assert property (i_modem_rx_timing && o_switched_active // RQ14
    && state_q.rx_ctrl[2] |=> o_rx_switched_go)
    else $error("switched reception not started at modem timing");

  rx_go_cause_a: assert property (o_rx_switched_go // RQ14
    |-> $past(i_modem_rx_timing))
    else $error("switched reception without modem timing");

  // ****************************************************************
  // checks of the register bus
  // ****************************************************************
  // answer lasts one cycle and carries the register contents
  apb_ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("bus answer longer than one cycle");

  apb_err_unmapped_a: assert property (setup_phase && !(hit_tx || hit_rx || hit_pre)
    |=> o_pready && o_pslverr)
    else $error("unmapped access not refused");

  apb_err_mapped_a: assert property (setup_phase && (hit_tx || hit_rx || hit_pre)
    |=> o_pready && !o_pslverr)
    else $error("mapped access refused");

  apb_rd_tx_a: assert property (setup_phase && !i_pwrite && hit_tx // RQ8
    |=> o_prdata == {24'h00_0000, $past(state_q.tx_ctrl)})
    else $error("transmit control read data wrong");

  apb_rd_rx_a: assert property (setup_phase && !i_pwrite && hit_rx // RQ15
    |=> o_prdata[31:3] == 29'h0000_0000)
    else $error("receive control reserved bits not zero");

  apb_rd_rx_val_a: assert property (setup_phase && !i_pwrite && hit_rx // RQ16
    |=> o_prdata[2:0] == $past(state_q.rx_ctrl))
    else $error("receive control read data wrong");

  apb_rd_pre_a: assert property (setup_phase && !i_pwrite && hit_pre // RQ11
    |=> o_prdata[31:10] == 22'h00_0000)
    else $error("preamble reserved bits not zero");

  apb_rd_pre_val_a: assert property (setup_phase && !i_pwrite && hit_pre // RQ10
    |=> o_prdata[9:0] == $past(state_q.preamble))
    else $error("preamble read data wrong");

  apb_rd_idle_a: assert property (!setup_phase |=> o_prdata == 32'h0000_0000)
    else $error("read data outside access cycle");

  reset_bus_a: assert property ($rose(!i_reset) |-> !o_pready && !o_pslverr)
    else $error("bus answer active after reset");

endmodule : smpc_top

// ### tb/smpc_top_bench.sv
`timescale 1ns/1ps
module smpc_top_bench;
  // ****************************************************************
  // stimulus and observation signals
  // ****************************************************************
  logic i_clk = 0, i_reset = 1, psel = 0, pen = 0, pwr = 0, msf = 0, trg = 0, tim = 0;
  logic [17:0] pa = 18'h00000;
  logic [31:0] wd = 32'h00000000, prdata, rd, r, seed = 32'h00005749;
  logic pready, pslverr, err, act, go;
  logic [7:0] b;
  logic [9:0] p;
  smpc_pkg::smpc_tx_cfg_t cfg;
  int errors = 0, n_checks = 0;

  smpc_top dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_msf_rx(msf), .i_rx_trigger(trg),
    .i_modem_rx_timing(tim), .o_tx_cfg(cfg), .o_switched_active(act),
    .o_rx_switched_go(go));

  // clock of 100 ns
  always #50 i_clk = ~i_clk;

  // xorshift source
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand

  // expected transmit configuration from register contents
  function automatic smpc_pkg::smpc_tx_cfg_t exp_cfg(logic [7:0] c, logic [9:0] n);
    smpc_pkg::smpc_tx_cfg_t e;
    e = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], c[7], n};
    return e;
  endfunction : exp_cfg

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // one apb transfer, held until pready is sampled high
  task automatic apb(logic w, logic [17:0] a, logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    wd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        return;
      end
    end
    errors++;
    finish_test();
  endtask : apb

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    apb(0, smpc_pkg::TX_FSK_CTRL1_ADDR, 0);
    chk("tx_ctrl_rst", rd, 32'h0000000C);
    chk("slverr_ok", {31'h0, err}, 32'h00000000);
    apb(0, smpc_pkg::RX_CTRL0_ADDR, 0);
    chk("rx_ctrl_rst", rd, 32'h00000000);
    apb(0, smpc_pkg::TX_PREAMBLE_ADDR, 0);
    chk("preamble_rst", rd, 32'h00000010);
    chk("cfg_rst", 32'(cfg), 32'(exp_cfg(8'h0C, 10'h010)));
    for (int i = 0; i < 12; i++) begin
      r = next_rand();
      b = (i == 0) ? 8'hFF : (i == 1) ? 8'h40 : r[7:0];
      p = (i == 0) ? 10'h004 : (i == 1) ? 10'h3E8 : 10'(r[25:16] % 997 + 4);
      if (!b[1]) b[6] = 1'b1;
      apb(1, smpc_pkg::TX_FSK_CTRL1_ADDR, {24'h0, b});
      apb(1, smpc_pkg::TX_PREAMBLE_ADDR, {22'h0, p});
      #1 chk("tx_cfg", 32'(cfg), 32'(exp_cfg(b, p)));
      apb(0, smpc_pkg::TX_FSK_CTRL1_ADDR, 0);
      chk("tx_ctrl_rd", rd, {24'h0, b});
      apb(0, smpc_pkg::TX_PREAMBLE_ADDR, 0);
      chk("preamble_rd", rd, {22'h0, p});
    end
    // unmapped place is refused
    apb(0, 18'h00000, 0);
    chk("unmapped_err", {31'h0, err}, 32'h00000001);
    chk("unmapped_rd", rd, 32'h00000000);
    // switched receive sequence
    apb(1, smpc_pkg::RX_CTRL0_ADDR, 32'h00000007);
    @(posedge i_clk) msf <= 1'b1;
    @(posedge i_clk) msf <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk("active_wait", {31'h0, act}, 32'h00000000);
    @(posedge i_clk) trg <= 1'b1;
    @(posedge i_clk) trg <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk("active_set", {31'h0, act}, 32'h00000001);
    @(posedge i_clk) tim <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk("go_on", {31'h0, go}, 32'h00000001);
    apb(1, smpc_pkg::RX_CTRL0_ADDR, 32'h00000003);
    repeat (3) @(posedge i_clk);
    #1 chk("go_blocked", {31'h0, go}, 32'h00000000);
    chk("active_kept", {31'h0, act}, 32'h00000001);
    apb(1, smpc_pkg::RX_CTRL0_ADDR, 32'h00000000);
    repeat (2) @(posedge i_clk);
    #1 chk("active_drop", {31'h0, act}, 32'h00000000);
    finish_test();
  end
endmodule : smpc_top_bench
